// >>> verification/sac_cache_bench.sv
`timescale 1ns/100ps
module sac_cache_bench;
    typedef struct packed {logic hit; logic flush; logic chk; logic [63:0] data;} sac_exp_t;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0, req_write_in = 1'b0;
    logic req_fetch_in = 1'b0, serialize_in = 1'b0, fill_shared_in = 1'b0;
    logic [31:0] req_paddr_in = 32'h0, seed, a, c;
    logic [63:0] req_wdata_in = 64'h0;
    logic [7:0] req_wbe_in = 8'h0;
    logic [3:0] infl_valid_in = 4'h0, dly_in = 4'h3;
    logic [127:0] infl_paddr_in = 128'h0, fill_data_in, ln, lc;
    logic resp_valid_out, resp_hit_out, req_ready_out, pipe_flush_out, prefetch_discard_out;
    logic fill_req_out, fill_valid_in;
    logic [63:0] resp_rdata_out;
    logic [31:0] fill_paddr_out, ad[5];
    int mismatches = 0, checks_done = 0;
    sac_exp_t expq[$], ex;
    always #2.5 sys_clk_in = ~sys_clk_in;
    sac_cache dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_fetch_in(req_fetch_in), .req_paddr_in(req_paddr_in),
        .req_wdata_in(req_wdata_in), .req_wbe_in(req_wbe_in), .resp_valid_out(resp_valid_out),
        .resp_hit_out(resp_hit_out), .resp_rdata_out(resp_rdata_out),
        .req_ready_out(req_ready_out), .infl_valid_in(infl_valid_in),
        .infl_paddr_in(infl_paddr_in), .serialize_in(serialize_in),
        .pipe_flush_out(pipe_flush_out), .prefetch_discard_out(prefetch_discard_out),
        .fill_req_out(fill_req_out), .fill_paddr_out(fill_paddr_out),
        .fill_valid_in(fill_valid_in), .fill_data_in(fill_data_in),
        .fill_shared_in(fill_shared_in));
    sac_mem_model mem (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .fill_req_in(fill_req_out),
        .fill_paddr_in(fill_paddr_out), .dly_in(dly_in), .fill_valid_out(fill_valid_in),
        .fill_data_out(fill_data_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [63:0] rd(input logic [127:0] l, input logic [3:0] o);
        return 64'(l >> {o, 3'h0});
    endfunction : rd
    function automatic sac_exp_t mk(input logic h, f, k, input logic [63:0] d);
        return '{h, f, k, d};
    endfunction : mk
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic cmp_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (e !== g) begin
            mismatches++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : cmp_bit
    task automatic cmp_data(input string n, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (e !== g) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_data
    // Enters and leaves at a falling edge, so hits can go back to back
    task automatic acc(input logic wr, fe, input logic [31:0] ad_in, input logic [63:0] wd,
        input logic [7:0] be, input sac_exp_t e);
        if (req_ready_out !== 1'b1) begin
            req_valid_in = 1'b0;
            for (int n = 0; n < 100 && req_ready_out !== 1'b1; n++) @(negedge sys_clk_in);
            if (req_ready_out !== 1'b1) begin
                mismatches++;
                end_sim();
            end
        end
        req_valid_in = 1'b1;
        req_write_in = wr;
        req_fetch_in = fe;
        req_paddr_in = ad_in;
        req_wdata_in = wd;
        req_wbe_in = be;
        expq.push_back(e);
        @(negedge sys_clk_in);
    endtask : acc
    task automatic finish_test(input string name);
        req_valid_in = 1'b0;
        for (int n = 0; n < 200 && expq.size() > 0; n++) @(negedge sys_clk_in);
        if (expq.size() > 0) begin
            mismatches++;
            end_sim();
        end
        $display("Test %s done", name);
    endtask : finish_test
    always @(negedge sys_clk_in) begin
        if (resp_valid_out === 1'b1) begin
            if (expq.size() == 0) begin
                mismatches++;
                $display("Error resp expected none seen one");
            end else begin
                ex = expq.pop_front();
                cmp_bit("hit", ex.hit, resp_hit_out);
                cmp_bit("flush", ex.flush, pipe_flush_out);
                cmp_bit("discard", ex.flush, prefetch_discard_out);
                if (ex.chk) cmp_data("rdata", ex.data, resp_rdata_out);
            end
        end
    end
    initial begin
        seed = 32'h0000_B5CF;
        repeat (5) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        a = 32'h0001_2340;
        ln = mem.pat(a);
        acc(0, 0, a + 32'h4, 64'h0, 8'h0, mk(0, 0, 1, rd(ln, 4'h4)));
        acc(0, 0, a + 32'hC, 64'h0, 8'h0, mk(1, 0, 1, rd(ln, 4'hC)));
        acc(0, 0, a, 64'h0, 8'h0, mk(1, 0, 1, rd(ln, 4'h0)));
        finish_test("lookup");
        infl_valid_in = 4'h1;
        infl_paddr_in[31:0] = a;
        acc(1, 0, a + 32'h8, 64'h1122_3344_5566_7788, 8'h0F, mk(1, 0, 0, 64'h0));
        ln[64 +: 32] = 32'h5566_7788;
        acc(0, 0, a + 32'h8, 64'h0, 8'h0, mk(1, 0, 1, rd(ln, 4'h8)));
        finish_test("store");
        c = 32'h0004_5670;
        lc = mem.pat(c);
        dly_in = 4'h0;
        acc(0, 1, c, 64'h0, 8'h0, mk(0, 0, 1, rd(lc, 4'h0)));
        infl_valid_in = 4'h5;
        infl_paddr_in[95:64] = c + 32'h5;
        acc(1, 0, c, 64'hFFFF_FFFF_FFFF_FFFF, 8'hFF, mk(1, 1, 0, 64'h0));
        acc(0, 0, c, 64'h0, 8'h0, mk(0, 0, 1, rd(lc, 4'h0)));
        finish_test("smc");
        infl_valid_in = 4'h0;
        serialize_in = 1'b1;
        @(negedge sys_clk_in);
        serialize_in = 1'b0;
        cmp_bit("discard", 1'b1, prefetch_discard_out);
        $display("Test serialise done");
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            ad[k] = {8'(k), seed[15:0], 4'hA, seed[3:0]}; // One set, so the fifth fill evicts
            fill_shared_in = seed[16];
            dly_in = {1'b0, seed[19:17]};
            acc(0, 0, ad[k], 64'h0, 8'h0, mk(0, 0, 1, rd(mem.pat(ad[k]), ad[k][3:0])));
        end
        acc(0, 0, ad[0], 64'h0, 8'h0, mk(0, 0, 1, rd(mem.pat(ad[0]), ad[0][3:0])));
        acc(0, 0, ad[4], 64'h0, 8'h0, mk(1, 0, 1, rd(mem.pat(ad[4]), ad[4][3:0])));
        finish_test("evict");
        end_sim();
    end
endmodule : sac_cache_bench

// >>> verification/sac_cache_monitor.sv
`timescale 1ns/100ps
module sac_cache_monitor #(parameter int PA_W = 32, parameter int INFLIGHT = 4) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Lookup
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_ready_out,
    input wire logic [PA_W-1:0] req_paddr_in,
    input wire logic resp_valid_out,
    input wire logic resp_hit_out,
    // Pipeline
    input wire logic [INFLIGHT-1:0] infl_valid_in,
    input wire logic [INFLIGHT*PA_W-1:0] infl_paddr_in,
    input wire logic serialize_in,
    input wire logic pipe_flush_out,
    input wire logic prefetch_discard_out,
    // Refill
    input wire logic fill_req_out,
    input wire logic [PA_W-1:0] fill_paddr_out,
    input wire logic fill_valid_in
);
    logic qw_match;
    always_comb begin
        qw_match = 1'b0;
        for (int i = 0; i < INFLIGHT; i++) begin
            if (infl_valid_in[i] && infl_paddr_in[i*PA_W+3 +: PA_W-3] == req_paddr_in[PA_W-1:3]) begin
                qw_match = 1'b1;
            end
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_take;
        req_valid_in && req_ready_out;
    endsequence
    sequence s_miss;
        s_take ##1 fill_req_out;
    endsequence
    take_answer_a: assert property (s_take |=> resp_valid_out || fill_req_out)
        else $error("Request got no answer");
    miss_block_a: assert property (s_miss |-> !resp_valid_out && !req_ready_out)
        else $error("Miss answered or ready too early");
    fill_answer_a: assert property (fill_req_out && fill_valid_in |=> resp_valid_out && !resp_hit_out && req_ready_out)
        else $error("Refill not answered as miss");
    resp_cause_a: assert property (resp_valid_out |-> $past(req_valid_in && req_ready_out) || $past(fill_valid_in && fill_req_out))
        else $error("Answer without cause");
    fill_hold_a: assert property (fill_req_out && !fill_valid_in |=> fill_req_out && $stable(fill_paddr_out))
        else $error("Refill request not held");
    fill_align_a: assert property (fill_req_out |-> fill_paddr_out[3:0] == 4'h0)
        else $error("Refill address not line aligned");
    flush_cause_a: assert property (pipe_flush_out |-> $past(req_valid_in && req_ready_out && req_write_in && qw_match) && prefetch_discard_out)
        else $error("Flush without matching store");
    ser_discard_a: assert property (serialize_in |=> prefetch_discard_out)
        else $error("Serialise did not discard");
    discard_cause_a: assert property (prefetch_discard_out |-> $past(serialize_in) || pipe_flush_out)
        else $error("Discard without cause");
endmodule : sac_cache_monitor
bind sac_cache sac_cache_monitor #(.PA_W(PA_W), .INFLIGHT(INFLIGHT)) u_mon (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_ready_out(req_ready_out), .req_paddr_in(req_paddr_in),
    .resp_valid_out(resp_valid_out), .resp_hit_out(resp_hit_out), .infl_valid_in(infl_valid_in),
    .infl_paddr_in(infl_paddr_in), .serialize_in(serialize_in), .pipe_flush_out(pipe_flush_out),
    .prefetch_discard_out(prefetch_discard_out), .fill_req_out(fill_req_out),
    .fill_paddr_out(fill_paddr_out), .fill_valid_in(fill_valid_in));

// >>> verification/sac_mem_model.sv
`timescale 1ns/100ps
module sac_mem_model (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Refill side
    input wire logic fill_req_in,
    input wire logic [31:0] fill_paddr_in,
    input wire logic [3:0] dly_in,
    output logic fill_valid_out,
    output logic [127:0] fill_data_out
);
    logic [3:0] cnt;
    // Lines differ unless a[15:8] + 16*a[7:4] matches (mod 256), so a wrong way or set shows
    function automatic logic [127:0] pat(input logic [31:0] a);
        for (int i = 0; i < 16; i++) begin
            pat[i*8 +: 8] = a[15:8] + {a[7:4], 4'(i)};
        end
    endfunction : pat
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= 4'h0;
            fill_valid_out <= 1'b0;
            fill_data_out <= 128'h0;
        end else if (fill_valid_out) begin
            // Released data is scrambled so a late sample fails
            fill_valid_out <= 1'b0;
            fill_data_out <= ~fill_data_out;
        end else if (fill_req_in) begin
            if (cnt >= dly_in) begin
                cnt <= 4'h0;
                fill_valid_out <= 1'b1;
                fill_data_out <= pat(fill_paddr_in);
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : sac_mem_model

// >>> verilog/sac_cache.sv
`timescale 1ns/100ps
// Overview of operation
// RULE1 - Cache is an array of lines: data block, tag, extra info.
// RULE2 - Lines form sets (rows) and ways (columns); n lines per set.
// RULE3 - Physical address splits into index, tag and byte offset.
// RULE4 - Index selects one set; all its ways are compared together.
// RULE5 - Tag match in any way gives hit and selects it; else miss.
// RULE6 - Offset gives first byte; reads return, writes update from there.
// RULE7 - Hitting way's data goes out through an n to 1 multiplexor.
// RULE8 - Each line keeps coherence state, replacement state, optional predecode.
// RULE9 - Store hitting an instruction line invalidates that line.
// RULE10 - Store into in-flight instruction flushes pipeline and restarts fetch.
// RULE11 - Store versus in-flight comparison uses physical addresses.
// RULE12 - Written cacheable code may stay shared; refill from any coherent level.
// RULE13 - Stores become visible to fetch in program order.
// RULE14 - Fetch reads ascending between branches; may re-read same quadword.
// RULE15 - Single store into quadword is atomic to fetchers.
// RULE16 - Software keeps unsynchronised updates within one aligned quadword.
// RULE17 - Released thread runs serialising instruction before modified code.
// RULE18 - Serialising instruction discards speculatively prefetched bytes.
// RULE19 - Miss picks victim by replacement state, then fills line and tag.
module sac_cache #(
    parameter int WAYS = sac_pkg::WAYS,
    parameter int SETS = sac_pkg::SETS,
    parameter int LINE_BYTES = sac_pkg::LINE_BYTES,
    parameter int PA_W = sac_pkg::PA_W,
    parameter int INFLIGHT = sac_pkg::INFLIGHT
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Load/store and fetch lookup
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_fetch_in,
    input wire logic [PA_W-1:0] req_paddr_in,
    input wire logic [sac_pkg::DATA_BYTES*8-1:0] req_wdata_in,
    input wire logic [sac_pkg::DATA_BYTES-1:0] req_wbe_in,
    output logic resp_valid_out,
    output logic resp_hit_out,
    output logic [sac_pkg::DATA_BYTES*8-1:0] resp_rdata_out,
    output logic req_ready_out,
    // In-flight instruction addresses
    input wire logic [INFLIGHT-1:0] infl_valid_in,
    input wire logic [INFLIGHT*PA_W-1:0] infl_paddr_in,
    input wire logic serialize_in,
    output logic pipe_flush_out,
    output logic prefetch_discard_out,
    // Memory hierarchy refill
    output logic fill_req_out,
    output logic [PA_W-1:0] fill_paddr_out,
    input wire logic fill_valid_in,
    input wire logic [LINE_BYTES*8-1:0] fill_data_in,
    input wire logic fill_shared_in
);
    localparam int OFF_W = $clog2(LINE_BYTES);
    localparam int IDX_W = $clog2(SETS);
    localparam int TAG_W = PA_W - OFF_W - IDX_W;
    localparam int WAY_W = (WAYS > 1) ? $clog2(WAYS) : 1;
    localparam int DB = sac_pkg::DATA_BYTES;
    localparam int QW_W = $clog2(DB);

    initial begin
        if (WAYS < 2 || (1 << WAY_W) != WAYS || (1 << IDX_W) != SETS ||
            (1 << OFF_W) != LINE_BYTES || LINE_BYTES < DB || TAG_W < 1) begin
            $error("sac_cache: unsupported geometry");
        end
    end

    // Line storage: data, tag, coherence, replacement age
    logic [LINE_BYTES*8-1:0] line_data [SETS][WAYS]; // see RULE1, see RULE2
    logic [TAG_W-1:0] line_tag [SETS][WAYS];
    sac_pkg::sac_moesi_t line_state [SETS][WAYS]; // see RULE8
    logic [WAY_W-1:0] line_age [SETS][WAYS];
    logic line_icode [SETS][WAYS];

    // Address split
    logic [OFF_W-1:0] a_off;
    logic [IDX_W-1:0] a_idx;
    logic [TAG_W-1:0] a_tag;
    assign a_off = req_paddr_in[OFF_W-1:0]; // see RULE3
    assign a_idx = req_paddr_in[OFF_W +: IDX_W];
    assign a_tag = req_paddr_in[PA_W-1 -: TAG_W];

    // Parallel tag compare across the indexed set
    logic [WAYS-1:0] way_hit;
    genvar gw;
    generate
        for (gw = 0; gw < WAYS; gw++) begin : g_cmp
            assign way_hit[gw] = (line_state[a_idx][gw] != sac_pkg::SAC_INV) &&
                                 (line_tag[a_idx][gw] == a_tag); // see RULE4, see RULE5
        end
    endgenerate

    logic hit;
    logic [WAY_W-1:0] hit_way;
    logic [WAY_W-1:0] victim;
    logic [LINE_BYTES*8-1:0] hit_line;
    always_comb begin
        hit = 1'b0;
        hit_way = '0;
        victim = '0;
        for (int w = 0; w < WAYS; w++) begin
            if (way_hit[w]) begin
                hit = 1'b1;
                hit_way = WAY_W'(w);
            end
        end
        // Invalid way first, otherwise the oldest
        for (int w = WAYS-1; w >= 0; w--) begin
            if (line_age[a_idx][w] == WAY_W'(WAYS-1)) begin
                victim = WAY_W'(w); // see RULE19
            end
        end
        for (int w = WAYS-1; w >= 0; w--) begin
            if (line_state[a_idx][w] == sac_pkg::SAC_INV) begin
                victim = WAY_W'(w);
            end
        end
        hit_line = line_data[a_idx][hit_way]; // see RULE7
    end

    // In-flight physical address overlap check
    logic [INFLIGHT-1:0] infl_match;
    generate
        for (gw = 0; gw < INFLIGHT; gw++) begin : g_infl
            assign infl_match[gw] = infl_valid_in[gw] &&
                (infl_paddr_in[gw*PA_W+QW_W +: PA_W-QW_W] ==
                 req_paddr_in[PA_W-1:QW_W]); // see RULE11
        end
    endgenerate

    sac_pkg::sac_state_t state;
    logic [PA_W-1:0] miss_addr;
    logic miss_write;
    logic miss_fetch;
    logic [DB*8-1:0] miss_wdata;
    logic [DB-1:0] miss_wbe;
    logic [WAY_W-1:0] miss_way;

    // Requests taken one at a time, in order, so stores reach fetch in program order
    assign req_ready_out = (state == sac_pkg::SAC_IDLE); // see RULE13
    logic take;
    assign take = req_valid_in && req_ready_out;

    // Byte merge at the offset; whole store applied in one edge
    function automatic logic [LINE_BYTES*8-1:0] merge(
        input logic [LINE_BYTES*8-1:0] line,
        input logic [OFF_W-1:0] off,
        input logic [DB*8-1:0] wd,
        input logic [DB-1:0] be);
        logic [LINE_BYTES*8-1:0] r;
        r = line;
        for (int b = 0; b < DB; b++) begin
            if (be[b] && (int'(off) + b) < LINE_BYTES) begin
                r[(int'(off)+b)*8 +: 8] = wd[b*8 +: 8]; // see RULE6, see RULE15
            end
        end
        return r;
    endfunction : merge

    function automatic logic [DB*8-1:0] extract(
        input logic [LINE_BYTES*8-1:0] line,
        input logic [OFF_W-1:0] off);
        logic [DB*8-1:0] r;
        r = '0;
        for (int b = 0; b < DB; b++) begin
            if ((int'(off) + b) < LINE_BYTES) begin
                r[b*8 +: 8] = line[(int'(off)+b)*8 +: 8]; // see RULE6
            end
        end
        return r;
    endfunction : extract

    // Sequencer
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= sac_pkg::SAC_IDLE;
        end else begin
            unique case (state)
                sac_pkg::SAC_IDLE: begin
                    if (take && !hit) begin
                        state <= sac_pkg::SAC_FILL;
                    end
                end
                sac_pkg::SAC_FILL: begin
                    if (fill_valid_in) begin
                        state <= sac_pkg::SAC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            miss_addr <= '0;
            miss_write <= 1'b0;
            miss_fetch <= 1'b0;
            miss_wdata <= '0;
            miss_wbe <= '0;
            miss_way <= '0;
        end else if (take && !hit) begin
            miss_addr <= req_paddr_in;
            miss_write <= req_write_in;
            miss_fetch <= req_fetch_in;
            miss_wdata <= req_wdata_in;
            miss_wbe <= req_wbe_in;
            miss_way <= victim;
        end
    end

    logic [IDX_W-1:0] m_idx;
    assign m_idx = miss_addr[OFF_W +: IDX_W];

    // Line array update: hits, SMC invalidation, refills
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int s = 0; s < SETS; s++) begin
                for (int w = 0; w < WAYS; w++) begin
                    line_data[s][w] <= '0;
                    line_tag[s][w] <= '0;
                    line_state[s][w] <= sac_pkg::SAC_INV;
                    line_age[s][w] <= WAY_W'(w);
                    line_icode[s][w] <= 1'b0;
                end
            end
        end else if (state == sac_pkg::SAC_FILL && fill_valid_in) begin
            for (int w = 0; w < WAYS; w++) begin
                if (line_age[m_idx][w] < line_age[m_idx][miss_way]) begin
                    line_age[m_idx][w] <= line_age[m_idx][w] + WAY_W'(1);
                end
            end
            line_age[m_idx][miss_way] <= '0; // see RULE19
            line_tag[m_idx][miss_way] <= miss_addr[PA_W-1 -: TAG_W];
            line_icode[m_idx][miss_way] <= miss_fetch;
            if (miss_write) begin
                line_data[m_idx][miss_way] <=
                    merge(fill_data_in, miss_addr[OFF_W-1:0], miss_wdata, miss_wbe);
                line_state[m_idx][miss_way] <= sac_pkg::SAC_MOD;
            end else begin
                line_data[m_idx][miss_way] <= fill_data_in; // see RULE12
                line_state[m_idx][miss_way] <= fill_shared_in ? sac_pkg::SAC_SHR
                                                              : sac_pkg::SAC_EXC;
            end
        end else if (take && hit) begin
            for (int w = 0; w < WAYS; w++) begin
                if (line_age[a_idx][w] < line_age[a_idx][hit_way]) begin
                    line_age[a_idx][w] <= line_age[a_idx][w] + WAY_W'(1);
                end
            end
            line_age[a_idx][hit_way] <= '0;
            if (req_fetch_in) begin
                line_icode[a_idx][hit_way] <= 1'b1;
            end else if (req_write_in && line_icode[a_idx][hit_way]) begin
                // Stale code must not be fetched again from this line
                line_state[a_idx][hit_way] <= sac_pkg::SAC_INV; // see RULE9
                line_icode[a_idx][hit_way] <= 1'b0;
            end else if (req_write_in) begin
                line_data[a_idx][hit_way] <=
                    merge(hit_line, a_off, req_wdata_in, req_wbe_in);
                line_state[a_idx][hit_way] <= sac_pkg::SAC_MOD;
            end
        end
    end

    // Responses and flush pulses
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            resp_valid_out <= 1'b0;
            resp_hit_out <= 1'b0;
            resp_rdata_out <= '0;
        end else begin
            resp_valid_out <= (take && hit) ||
                              (state == sac_pkg::SAC_FILL && fill_valid_in);
            resp_hit_out <= take && hit;
            if (take && hit) begin
                resp_rdata_out <= extract(hit_line, a_off); // see RULE14
            end else if (state == sac_pkg::SAC_FILL && fill_valid_in) begin
                resp_rdata_out <= extract(fill_data_in, miss_addr[OFF_W-1:0]);
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pipe_flush_out <= 1'b0;
            prefetch_discard_out <= 1'b0;
        end else begin
            pipe_flush_out <= take && req_write_in && !req_fetch_in &&
                              (|infl_match); // see RULE10
            prefetch_discard_out <= serialize_in ||
                                    (take && req_write_in && (|infl_match)); // see RULE18
        end
    end

    assign fill_req_out = (state == sac_pkg::SAC_FILL);
    assign fill_paddr_out = {miss_addr[PA_W-1:OFF_W], {OFF_W{1'b0}}};
endmodule : sac_cache

// >>> verilog/sac_pkg.sv
package sac_pkg;
    // Geometry defaults
    localparam int WAYS = 4;
    localparam int SETS = 16;
    localparam int LINE_BYTES = 16;
    localparam int PA_W = 32;
    localparam int DATA_BYTES = 8;
    localparam int INFLIGHT = 4;
    // Coherence states
    typedef enum logic [2:0] {
        SAC_INV = 3'h0,
        SAC_SHR = 3'h1,
        SAC_EXC = 3'h2,
        SAC_OWN = 3'h3,
        SAC_MOD = 3'h4
    } sac_moesi_t;
    // Fill sequencer states, one-hot
    typedef enum logic [1:0] {
        SAC_IDLE = 2'h1,
        SAC_FILL = 2'h2
    } sac_state_t;
endpackage : sac_pkg
